// *** design/rfs_top.sv ***
// Fault supervisor and strap decoder of a two-phase regulator, AXI4-Lite regs
// Assumes comparator levels, temperature codes and strap bins from analog
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "rfs_defines.svh"

module rfs_top #(
   parameter int unsigned RETRY_CYCLES = `RFS_RETRY_MS * `RFS_CLK_KHZ,
   parameter int unsigned TEMP_W       = 8
) (
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic              analog_core_supply_ok_i,
   input  wire logic              controller_supply_ok_i,
   input  wire logic              high_voltage_supply_ok_i,
   input  wire logic [TEMP_W-1:0] int_temp_i,
   input  wire logic [TEMP_W-1:0] ext_stage_fault_temp_pin_i,
   input  wire logic              ext_stage_present_i,
   input  wire logic              sense_positive_open_i,
   input  wire logic              vout_over_i,
   input  wire logic              vout_under_i,
   input  wire logic              peak_overcurrent_i,
   input  wire logic              output_enable_i,
   input  wire logic [5:0]        addr_strap_bin_i,
   input  wire logic [5:0]        voltage_strap_bin_i,
   input  wire logic [5:0]        compensation_strap_bin_i,
   output logic                   switching_en_o,
   output logic                   duty_truncate_o,
   output logic                   power_good_output_o,
   output logic                   alert_o,
   output logic [6:0]             bus_addr_o,
   output logic [12:0]            setpoint_mv_o,
   output logic [2:0]             loop_gain_o,
   output logic [1:0]             loop_zero_o,
   input  wire logic [4:0]        s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic [4:0]        s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i
);
   localparam int unsigned SYN_W = 9 + 2 * TEMP_W + 18;
   localparam int unsigned CNT_W = $clog2(RETRY_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RETRY_CYCLES - 1);

   // Two-flop synchroniser on every pin but clock, reset and AXI4-Lite port; temps and straps are quasi-static
   logic [SYN_W-1:0] raw;
   logic [SYN_W-1:0] meta_q;
   logic [SYN_W-1:0] sync_q;
   assign raw = {analog_core_supply_ok_i, controller_supply_ok_i,
                 high_voltage_supply_ok_i, ext_stage_present_i,
                 sense_positive_open_i, vout_over_i, vout_under_i,
                 peak_overcurrent_i, output_enable_i, int_temp_i,
                 ext_stage_fault_temp_pin_i, addr_strap_bin_i,
                 voltage_strap_bin_i, compensation_strap_bin_i};
   genvar gi;
   generate
      for (gi = 0; gi < SYN_W; gi++) begin : g_sync
         always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end else begin
               meta_q[gi] <= raw[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   wire              ac_ok   = sync_q[SYN_W-1];
   wire              ctl_ok  = sync_q[SYN_W-2];
   wire              hv_ok   = sync_q[SYN_W-3];
   wire              ext_on  = sync_q[SYN_W-4];
   wire              sns_opn = sync_q[SYN_W-5];
   wire              ov_s    = sync_q[SYN_W-6];
   wire              uv_s    = sync_q[SYN_W-7];
   wire              poc_s   = sync_q[SYN_W-8];
   wire              en_s    = sync_q[SYN_W-9];
   wire [TEMP_W-1:0] tint    = sync_q[18+2*TEMP_W-1:18+TEMP_W];
   wire [TEMP_W-1:0] text    = sync_q[18+TEMP_W-1:18];
   wire [5:0]        a_bin   = sync_q[17:12];
   wire [5:0]        v_bin   = sync_q[11:6];
   wire [5:0]        c_bin   = sync_q[5:0];

   rfs_pkg::rfs_state_e state_q;
   rfs_pkg::rfs_state_e state_d;
   logic [CNT_W-1:0]    cnt_q;
   logic                en_q;
   logic [6:0]          status_q;
   logic [5:0]          resp_q;
   logic [7:0]          ot_lim_q;

   // Strap decode
   wire        addr_bad = a_bin[5];
   wire [6:0]  addr_dec = `RFS_ADDR_BASE + {2'b00, a_bin[4:0]};
   wire        v_step   = v_bin <= `RFS_VSET_LAST_BIN;
   wire        v_bad    = v_bin > `RFS_VSET_5V0_BIN;
   wire [12:0] v_lin    = `RFS_VSET_BASE + 13'(v_bin * `RFS_VSET_STEP);
   wire [12:0] v_rail   = (v_bin == `RFS_VSET_2V5_BIN) ? `RFS_VSET_2V5 :
                          (v_bin == `RFS_VSET_3V3_BIN) ? `RFS_VSET_3V3 :
                          `RFS_VSET_5V0;
   wire [12:0] v_dec    = v_step ? v_lin : v_rail;
   wire        c_bad    = c_bin[5];
   wire        strap_bad = addr_bad | v_bad | c_bad;

   // Fault conditions
   wire uvlo    = ~(ac_ok & ctl_ok & hv_ok);
   wire ot_hot  = (tint > TEMP_W'(ot_lim_q)) |
                  (ext_on & (text > TEMP_W'(ot_lim_q)));
   wire [1:0] r_ot = resp_q[1:0];
   wire [1:0] r_ov = resp_q[3:2];
   wire [1:0] r_uv = resp_q[5:4];
   wire ot_trip = ot_hot & (r_ot != rfs_pkg::RESP_IGNORE);
   wire ov_trip = ov_s & (r_ov != rfs_pkg::RESP_IGNORE);
   wire uv_trip = uv_s & (r_uv != rfs_pkg::RESP_IGNORE);
   wire any_trip = ot_trip | ov_trip | uv_trip;
   // A fault set to shutdown or to the reserved code wins over a retrying one
   wire stop_only = (ot_trip & (r_ot != rfs_pkg::RESP_RETRY)) |
                    (ov_trip & (r_ov != rfs_pkg::RESP_RETRY)) |
                    (uv_trip & (r_uv != rfs_pkg::RESP_RETRY));
   wire cnt_done = cnt_q == CNT_LAST;
   // Undervoltage is not rechecked: the output is off, so it always shows
   wire retry_ok = ~ot_hot & ~ov_s;
   wire en_rise  = en_s & ~en_q;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         rfs_pkg::S_INIT:  state_d = rfs_pkg::S_STRAP;
         rfs_pkg::S_STRAP: state_d = (strap_bad | sns_opn) ?
                                     rfs_pkg::S_LOCK :
                                     rfs_pkg::S_WAIT;
         rfs_pkg::S_WAIT:  if (en_s) state_d = rfs_pkg::S_RUN;
         rfs_pkg::S_RUN: begin
            if (!en_s) begin
               state_d = rfs_pkg::S_WAIT;
            end else if (any_trip) begin
               state_d = stop_only ? rfs_pkg::S_HALT : rfs_pkg::S_RETRY;
            end
         end
         rfs_pkg::S_RETRY: begin
            if (!en_s) begin
               state_d = rfs_pkg::S_WAIT;
            end else if (cnt_done && retry_ok) begin
               state_d = rfs_pkg::S_RUN;
            end
         end
         rfs_pkg::S_HALT:  if (!en_s) state_d = rfs_pkg::S_WAIT;
         rfs_pkg::S_LOCK:  state_d = rfs_pkg::S_LOCK;
         rfs_pkg::S_UVLO:  if (!uvlo) state_d = rfs_pkg::S_INIT;
      endcase
      if (uvlo) state_d = rfs_pkg::S_UVLO;
   end
   // Counter restarts on entry and on every failed recheck
   wire retry_entry = (state_d == rfs_pkg::S_RETRY) &&
                      ((state_q != rfs_pkg::S_RETRY) || cnt_done);
   wire [CNT_W-1:0] cnt_d = retry_entry ? '0 :
                            (cnt_done ? cnt_q : cnt_q + 1'b1);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= rfs_pkg::S_INIT;
         cnt_q   <= '0;
         en_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         en_q    <= en_s;
      end
   end

   // AXI4-Lite write path
   logic        aw_held_q;
   logic [4:0]  awaddr_q;
   logic        w_held_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        awready_q;
   logic        wready_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   wire aw_take   = s_axi_awvalid_i & awready_q;
   wire w_take    = s_axi_wvalid_i & wready_q;
   wire do_wr     = aw_held_q & w_held_q & ~bvalid_q;
   wire aw_held_d = ~do_wr & (aw_held_q | aw_take);
   wire w_held_d  = ~do_wr & (w_held_q | w_take);
   wire bvalid_d  = do_wr | (bvalid_q & ~s_axi_bready_i);
   wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                        {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire wr_status = do_wr & (awaddr_q == `RFS_OFF_STATUS);
   wire wr_resp   = do_wr & (awaddr_q == `RFS_OFF_RESP);
   wire wr_otl    = do_wr & (awaddr_q == `RFS_OFF_OT_LIMIT);
   wire wr_set    = do_wr & (awaddr_q == `RFS_OFF_SETPOINT);
   wire wr_loop   = do_wr & (awaddr_q == `RFS_OFF_LOOP);
   wire wr_map    = wr_status | wr_resp | wr_otl | wr_set | wr_loop |
                    (awaddr_q == `RFS_OFF_STATE);
   wire [31:0] wd = wdata_q & wmask;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RFS_AXI_OKAY;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q  <= w_held_d;
         awaddr_q  <= aw_take ? {s_axi_awaddr_i[4:2], 2'b00} : awaddr_q;
         wdata_q   <= w_take ? s_axi_wdata_i : wdata_q;
         wstrb_q   <= w_take ? s_axi_wstrb_i : wstrb_q;
         awready_q <= ~aw_held_d & ~bvalid_d;
         wready_q  <= ~w_held_d & ~bvalid_d;
         bvalid_q  <= bvalid_d;
         if (do_wr) bresp_q <= wr_map ? `RFS_AXI_OKAY : `RFS_AXI_SLVERR;
      end
   end
   // Sticky flags: hardware set beats a clear in the same cycle
   wire running = state_q == rfs_pkg::S_RUN;
   wire in_strap = state_q == rfs_pkg::S_STRAP;
   logic [6:0] st_set;
   assign st_set[`RFS_ST_OT]        = ot_hot;
   assign st_set[`RFS_ST_OV]        = running & ov_s;
   assign st_set[`RFS_ST_UV]        = running & uv_s;
   assign st_set[`RFS_ST_STRAP]     = in_strap & strap_bad;
   assign st_set[`RFS_ST_SENSE]     = in_strap & sns_opn;
   assign st_set[`RFS_ST_HV_UVLO]   = ~hv_ok;
   assign st_set[`RFS_ST_CTRL_UVLO] = ~ctl_ok;
   wire [6:0] st_clr = (wr_status ? wd[6:0] : 7'h00) |
                       {7{en_rise}};
   wire [6:0] status_d = (status_q & ~st_clr) | st_set;

   // Host overrides; strap load in S_STRAP has priority
   logic [12:0] setp_q;
   logic [2:0]  gain_q;
   logic [1:0]  zero_q;
   logic [6:0]  addr_q;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_q <= '0;
         resp_q   <= `RFS_RESP_RST;
         ot_lim_q <= `RFS_OT_LIMIT_RST;
         setp_q   <= '0;
         gain_q   <= '0;
         zero_q   <= '0;
         addr_q   <= '0;
      end else begin
         status_q <= status_d;
         if (wr_resp) resp_q <= (resp_q & ~wmask[5:0]) | wd[5:0];
         if (wr_otl) ot_lim_q <= (ot_lim_q & ~wmask[7:0]) | wd[7:0];
         if (in_strap) begin
            setp_q <= v_dec;
            gain_q <= c_bin[2:0];
            zero_q <= c_bin[4:3];
            addr_q <= addr_dec;
         end else begin
            if (wr_set) setp_q <= (setp_q & ~wmask[12:0]) | wd[12:0];
            if (wr_loop) begin
               gain_q <= (gain_q & ~wmask[2:0]) | wd[2:0];
               zero_q <= (zero_q & ~wmask[5:4]) | wd[5:4];
            end
         end
      end
   end

   // AXI4-Lite read path
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   wire ar_take  = s_axi_arvalid_i & arready_q;
   wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready_i);
   wire [4:0] ra = {s_axi_araddr_i[4:2], 2'b00};
   wire rd_map = (ra == `RFS_OFF_STATUS) | (ra == `RFS_OFF_RESP) |
                 (ra == `RFS_OFF_OT_LIMIT) | (ra == `RFS_OFF_SETPOINT) |
                 (ra == `RFS_OFF_LOOP) | (ra == `RFS_OFF_STATE);
   wire [31:0] rd_mux =
      (ra == `RFS_OFF_STATUS)   ? {25'h0, status_q} :
      (ra == `RFS_OFF_RESP)     ? {26'h0, resp_q} :
      (ra == `RFS_OFF_OT_LIMIT) ? {24'h0, ot_lim_q} :
      (ra == `RFS_OFF_SETPOINT) ? {19'h0, setp_q} :
      (ra == `RFS_OFF_LOOP)     ? {26'h0, zero_q, 1'b0, gain_q} :
      (ra == `RFS_OFF_STATE)    ? {17'h0, addr_q, 5'h0, state_q} :
      32'h0000_0000;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= `RFS_AXI_OKAY;
      end else begin
         arready_q <= ~rvalid_d;
         rvalid_q  <= rvalid_d;
         if (ar_take) begin
            rdata_q <= rd_mux;
            rresp_q <= rd_map ? `RFS_AXI_OKAY : `RFS_AXI_SLVERR;
         end
      end
   end

   // Outputs registered; switching and power good from next state, alert from next status, truncate from synced pin
   logic sw_q;
   logic pg_q;
   logic alert_q;
   logic trunc_q;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sw_q    <= 1'b0;
         pg_q    <= 1'b0;
         alert_q <= 1'b0;
         trunc_q <= 1'b0;
      end else begin
         sw_q    <= state_d == rfs_pkg::S_RUN;
         pg_q    <= (state_d == rfs_pkg::S_RUN) & ~ov_s & ~uv_s;
         alert_q <= |status_d;
         trunc_q <= poc_s;
      end
   end
   assign {switching_en_o, duty_truncate_o, power_good_output_o, alert_o} =
          {sw_q, trunc_q, pg_q, alert_q};
   assign {bus_addr_o, setpoint_mv_o, loop_gain_o, loop_zero_o} =
          {addr_q, setp_q, gain_q, zero_q};
   assign {s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_bresp_o} =
          {awready_q, wready_q, bvalid_q, bresp_q};
   assign {s_axi_arready_o, s_axi_rvalid_o, s_axi_rdata_o, s_axi_rresp_o} =
          {arready_q, rvalid_q, rdata_q, rresp_q};
endmodule : rfs_top

// *** design/rfs_defines.svh ***
// Offsets, field positions, reset values and timing counts of the supervisor
// Included by the top module
`ifndef RFS_DEFINES_SVH
`define RFS_DEFINES_SVH
`define RFS_OFF_STATUS    5'h00
`define RFS_OFF_RESP      5'h04
`define RFS_OFF_OT_LIMIT  5'h08
`define RFS_OFF_SETPOINT  5'h0C
`define RFS_OFF_LOOP      5'h10
`define RFS_OFF_STATE     5'h14
`define RFS_ST_OT         0
`define RFS_ST_OV         1
`define RFS_ST_UV         2
`define RFS_ST_STRAP      3
`define RFS_ST_SENSE      4
`define RFS_ST_HV_UVLO    5
`define RFS_ST_CTRL_UVLO  6
`define RFS_ST_W          7
`define RFS_OT_LIMIT_RST  8'h96
`define RFS_RESP_RST      6'h2A
`define RFS_ADDR_BASE     7'h10
`define RFS_VSET_BASE     13'h01F4
`define RFS_VSET_STEP     13'h0032
`define RFS_VSET_LAST_BIN 6'h1A
`define RFS_VSET_2V5_BIN  6'h1B
`define RFS_VSET_3V3_BIN  6'h1C
`define RFS_VSET_5V0_BIN  6'h1D
`define RFS_VSET_2V5      13'h09C4
`define RFS_VSET_3V3      13'h0CE4
`define RFS_VSET_5V0      13'h1388
`define RFS_RETRY_MS      50
`define RFS_CLK_KHZ       20000
`define RFS_AXI_OKAY      2'h0
`define RFS_AXI_SLVERR    2'h2
`endif

// *** design/rfs_pkg.sv ***
// Types shared by the regulator fault supervisor
// Assumes rfs_defines.svh holds the numeric constants
package rfs_pkg;
   typedef enum logic [2:0] {
      S_INIT   = 3'b000,
      S_STRAP  = 3'b001,
      S_WAIT   = 3'b010,
      S_RUN    = 3'b011,
      S_RETRY  = 3'b100,
      S_HALT   = 3'b101,
      S_LOCK   = 3'b110,
      S_UVLO   = 3'b111
   } rfs_state_e;

   typedef enum logic [1:0] {
      RESP_IGNORE   = 2'b00,
      RESP_SHUTDOWN = 2'b01,
      RESP_RETRY    = 2'b10,
      RESP_RSVD     = 2'b11
   } rfs_resp_e;
endpackage : rfs_pkg

// *** verif/rfs_checker.sv ***
// Port assertions for the regulator fault supervisor
// Assumes the temperature limit keeps its reset value during a run
`timescale 1ns/1ps
module rfs_checker #(
   parameter int unsigned RETRY_CYCLES = 20,
   parameter int unsigned TEMP_W       = 8
) (
   input wire logic              sys_clk_i,
   input wire logic              rst_i,
   input wire logic              analog_core_supply_ok_i,
   input wire logic              controller_supply_ok_i,
   input wire logic              high_voltage_supply_ok_i,
   input wire logic [TEMP_W-1:0] int_temp_i,
   input wire logic              output_enable_i,
   input wire logic              peak_overcurrent_i,
   input wire logic              switching_en_o,
   input wire logic              duty_truncate_o,
   input wire logic              power_good_output_o,
   input wire logic [4:0]        s_axi_araddr_i,
   input wire logic              s_axi_arvalid_i,
   input wire logic              s_axi_arready_o,
   input wire logic [31:0]       s_axi_rdata_o,
   input wire logic [1:0]        s_axi_rresp_o,
   input wire logic              s_axi_rvalid_o,
   input wire logic              s_axi_rready_i,
   input wire logic              s_axi_bvalid_o,
   input wire logic              s_axi_bready_i
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   wire sup_ok = analog_core_supply_ok_i & controller_supply_ok_i
                 & high_voltage_supply_ok_i;
   wire rd_take = s_axi_arvalid_i & s_axi_arready_o;

   a_uvlo_stops: assert property (!sup_ok [*6] |-> !switching_en_o)
      else $error("switching during supply lockout");
   a_hot_stops: assert property ((int_temp_i > 8'h96) [*6] |-> !switching_en_o)
      else $error("switching while over temperature");
   // A retry exit waits out the retry count and a halt waits for enable to drop, so eight idle edges is safe
   a_retry_wait: assert property ($fell(switching_en_o) && sup_ok
      && output_enable_i |-> !switching_en_o [*8])
      else $error("switching resumed too soon");
   a_pg_in_run: assert property (power_good_output_o |-> switching_en_o)
      else $error("power good without switching");
   a_trunc_follow: assert property (!$past(rst_i, 3) |->
      duty_truncate_o == $past(peak_overcurrent_i, 3))
      else $error("truncation does not follow overcurrent");
   a_rd_answer: assert property (rd_take |=> s_axi_rvalid_o)
      else $error("read answer late");
   a_unmapped_rd: assert property (rd_take && s_axi_araddr_i >= 5'h18
      |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_rd_release: assert property (s_axi_rvalid_o && s_axi_rready_i
      |=> !s_axi_rvalid_o)
      else $error("read answer repeated");
   a_wr_release: assert property (s_axi_bvalid_o && s_axi_bready_i
      |=> !s_axi_bvalid_o)
      else $error("write answer repeated");

   c_trip: cover property ($fell(switching_en_o));
   c_resume: cover property ($rose(switching_en_o));
   c_trunc: cover property (duty_truncate_o);
endmodule : rfs_checker

bind rfs_top rfs_checker #(.RETRY_CYCLES(RETRY_CYCLES), .TEMP_W(TEMP_W))
   i_chk (.*);

// *** verif/rfs_host_model.sv ***
// Register-bus host model; the bench calls its write and read tasks
// Assumes a slave on the same clock that answers each channel in time
`timescale 1ns/1ps
module rfs_host_model (
   input  wire logic        clk_i,
   output logic [4:0]       awaddr_o,
   output logic             awvalid_o,
   input  wire logic        awready_i,
   output logic [31:0]      wdata_o,
   output logic [3:0]       wstrb_o,
   output logic             wvalid_o,
   input  wire logic        wready_i,
   output logic             bready_o,
   input  wire logic        bvalid_i,
   output logic [4:0]       araddr_o,
   output logic             arvalid_o,
   input  wire logic        arready_i,
   output logic             rready_o,
   input  wire logic        rvalid_i
);
   initial begin
      {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o} = '0;
      {bready_o, araddr_o, arvalid_o, rready_o} = '0;
   end

   // Each channel is released only at the edge that takes it
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic aw_p, w_p;
      @(posedge clk_i);
      awaddr_o <= a;
      wdata_o <= d;
      wstrb_o <= 4'hF;
      {awvalid_o, wvalid_o, bready_o} <= 3'b111;
      aw_p = 1'b1;
      w_p = 1'b1;
      while (aw_p || w_p) begin
         @(posedge clk_i);
         if (aw_p && awready_i === 1'b1) begin
            aw_p = 1'b0;
            awvalid_o <= 1'b0;
         end
         if (w_p && wready_i === 1'b1) begin
            w_p = 1'b0;
            wvalid_o <= 1'b0;
         end
      end
      do @(posedge clk_i); while (bvalid_i !== 1'b1);
      bready_o <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a);
      @(posedge clk_i);
      araddr_o <= a;
      {arvalid_o, rready_o} <= 2'b11;
      do @(posedge clk_i); while (arready_i !== 1'b1);
      arvalid_o <= 1'b0;
      do @(posedge clk_i); while (rvalid_i !== 1'b1);
      rready_o <= 1'b0;
   endtask : rd
endmodule : rfs_host_model

// *** verif/regulator_fault_supervisor_tb_top.sv ***
// Self-checking bench of the fault supervisor with a register-bus host
// Assumes a short retry count so that each retry takes twenty cycles
`timescale 1ns/1ps
module regulator_fault_supervisor_tb_top;
   logic sys_clk_i, rst_i, output_enable_i, ext_stage_present_i;
   logic sense_positive_open_i, vout_over_i, vout_under_i;
   logic peak_overcurrent_i, switching_en_o, duty_truncate_o;
   logic power_good_output_o, alert_o;
   logic [2:0]  sup, loop_gain_o;
   logic [7:0]  int_temp_i, ext_stage_fault_temp_pin_i;
   logic [5:0]  addr_strap_bin_i, voltage_strap_bin_i;
   logic [5:0]  compensation_strap_bin_i, vbin;
   logic [6:0]  bus_addr_o;
   logic [12:0] setpoint_mv_o, vexp;
   logic [1:0]  loop_zero_o, s_axi_bresp_o, s_axi_rresp_o;
   logic [4:0]  s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o, r;
   logic [3:0]  s_axi_wstrb_i;
   logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
   logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
   logic s_axi_rvalid_o, s_axi_rready_i;
   logic [33:0] exp_q[$];
   int          err_total, checked;
   wire analog_core_supply_ok_i  = sup[0];
   wire controller_supply_ok_i   = sup[1];
   wire high_voltage_supply_ok_i = sup[2];

   rfs_top #(.RETRY_CYCLES(20)) i_dut (.*);
   rfs_host_model i_host (.clk_i(sys_clk_i), .awaddr_o(s_axi_awaddr_i),
      .awvalid_o(s_axi_awvalid_i), .awready_i(s_axi_awready_o),
      .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
      .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o),
      .bready_o(s_axi_bready_i), .bvalid_i(s_axi_bvalid_o),
      .araddr_o(s_axi_araddr_i), .arvalid_o(s_axi_arvalid_i),
      .arready_i(s_axi_arready_o), .rready_o(s_axi_rready_i),
      .rvalid_i(s_axi_rvalid_o));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task automatic check(input string nm, input logic [33:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   task automatic rd(input logic [4:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      i_host.rd(a);
   endtask : rd

   task automatic wait_sw(input logic v);
      int n;
      n = 0;
      while (switching_en_o !== v && n < 300) begin
         @(posedge sys_clk_i);
         n++;
      end
      check("switching", switching_en_o, v);
   endtask : wait_sw

   task automatic pulse(input int b);
      if (b < 3) sup[b] <= 1'b0;
      else output_enable_i <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      if (b < 3) sup[b] <= 1'b1;
      else output_enable_i <= 1'b1;
   endtask : pulse

   // Read answers are compared in order against the noted expectations
   always @(posedge sys_clk_i)
      if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i)
         check("read word", {s_axi_rresp_o, s_axi_rdata_o}, exp_q.pop_front());

   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   initial begin
      repeat (20000) @(posedge sys_clk_i);
      err_total++;
      report_and_stop();
   end

   initial begin
      r = lfsr(32'h0001_1A0C);
      {sup, rst_i, output_enable_i, ext_stage_present_i} = 6'b11_1111;
      {sense_positive_open_i, vout_over_i, vout_under_i} = 3'b000;
      peak_overcurrent_i = 1'b0;
      int_temp_i = 8'h19;
      ext_stage_fault_temp_pin_i = 8'h19;
      addr_strap_bin_i = {1'b0, r[4:0]};
      vbin = 6'(r[15:8] % 30);
      voltage_strap_bin_i = vbin;
      compensation_strap_bin_i = {1'b0, r[20:16]};
      case (vbin)
         6'h1B: vexp = 13'h09C4;
         6'h1C: vexp = 13'h0CE4;
         6'h1D: vexp = 13'h1388;
         default: vexp = 13'(13'h01F4 + 13'h0032 * vbin);
      endcase
      repeat (10) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      wait_sw(1'b1);
      check("address", bus_addr_o, 7'h10 + r[4:0]);
      check("setpoint", setpoint_mv_o, vexp);
      check("gain", loop_gain_o, r[18:16]);
      check("zero", loop_zero_o, r[20:19]);
      rd(5'h08, 34'h0_0000_0096);
      rd(5'h04, 34'h0_0000_002A);
      rd(5'h14, {19'h0_0000, 7'(7'h10 + r[4:0]), 8'h03});
      rd(5'h18, 34'h2_0000_0000);
      i_host.wr(5'h1C, 32'h0000_0001);
      check("write refused", s_axi_bresp_o, 2'h2);
      i_host.wr(5'h00, 32'h0000_007F);
      check("write taken", s_axi_bresp_o, 2'h0);
      peak_overcurrent_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      check("truncate", duty_truncate_o, 1'b1);
      rd(5'h00, 34'h0);
      peak_overcurrent_i <= 1'b0;
      int_temp_i <= 8'hC8;
      wait_sw(1'b0);
      repeat (30) @(posedge sys_clk_i);
      check("alert", alert_o, 1'b1);
      check("hot", switching_en_o, 1'b0);
      int_temp_i <= 8'h19;
      wait_sw(1'b1);
      rd(5'h00, 34'h1);
      i_host.wr(5'h00, 32'h0000_0001);
      rd(5'h00, 34'h0);
      i_host.wr(5'h04, 32'h0000_0021);
      ext_stage_fault_temp_pin_i <= 8'hC8;
      wait_sw(1'b0);
      ext_stage_fault_temp_pin_i <= 8'h19;
      repeat (60) @(posedge sys_clk_i);
      check("halt", switching_en_o, 1'b0);
      pulse(3);
      wait_sw(1'b1);
      rd(5'h00, 34'h0);
      for (int m = 0; m < 3; m++) begin
         i_host.wr(5'h04, 32'h0000_0022 | (m << 2));
         vout_over_i <= 1'b1;
         repeat (8) @(posedge sys_clk_i);
         check("ov run", switching_en_o, m == 0);
         check("ov good", power_good_output_o, 1'b0);
         vout_over_i <= 1'b0;
         repeat (40) @(posedge sys_clk_i);
         check("ov after", switching_en_o, m != 1);
         rd(5'h00, 34'h2);
         pulse(3);
         wait_sw(1'b1);
         rd(5'h00, 34'h0);
      end
      i_host.wr(5'h04, 32'h0000_0012);
      vout_under_i <= 1'b1;
      wait_sw(1'b0);
      vout_under_i <= 1'b0;
      rd(5'h00, 34'h4);
      pulse(3);
      wait_sw(1'b1);
      i_host.wr(5'h10, 32'h0000_0025);
      // A rise of one eighth of the strapped setpoint, written over the register bus
      i_host.wr(5'h0C, {19'h0_0000, 13'(vexp + (vexp >> 3))});
      @(posedge sys_clk_i);
      check("gain set", loop_gain_o, 3'h5);
      check("zero set", loop_zero_o, 2'h2);
      check("vout set", setpoint_mv_o, 13'(vexp + (vexp >> 3)));
      for (int s = 0; s < 3; s++) begin
         sup[s] <= 1'b0;
         repeat (8) @(posedge sys_clk_i);
         check("lockout", switching_en_o, 1'b0);
         sup[s] <= 1'b1;
         wait_sw(1'b1);
         check("reload", setpoint_mv_o, vexp);
      end
      i_host.wr(5'h00, 32'h0000_007F);
      for (int j = 0; j < 2; j++) begin
         if (j == 0) sense_positive_open_i <= 1'b1;
         else voltage_strap_bin_i <= 6'h1E;
         pulse(0);
         repeat (60) @(posedge sys_clk_i);
         check("locked", switching_en_o, 1'b0);
         check("lock alert", alert_o, 1'b1);
         rd(5'h00, j ? 34'h8 : 34'h10);
         sense_positive_open_i <= 1'b0;
         voltage_strap_bin_i <= vbin;
         pulse(0);
         wait_sw(1'b1);
         i_host.wr(5'h00, 32'h0000_007F);
      end
      report_and_stop();
   end
endmodule : regulator_fault_supervisor_tb_top
